// ===== src/gdr_pkg.sv
// constants, encodings and decode functions for the gate drive strength and fault register bank
package gdr_pkg;

   // serial word layout
   localparam int unsigned FRAME_BITS = 16;
   localparam int unsigned DATA_BITS = 11;
   localparam int unsigned ADDR_BITS = 4;
   localparam int unsigned RW_POS = 15;
   localparam int unsigned ADDR_MSB = 14;
   localparam int unsigned ADDR_LSB = 11;
   localparam logic [4:0] ADDR_DONE_CNT = 5'h04;
   localparam logic [4:0] FRAME_DONE_CNT = 5'h10;
   localparam logic RW_READ = 1'b1;

   // register offsets
   localparam logic [3:0] GATE_FAULT_FLAGS_ADDR = 4'h4;
   localparam logic [3:0] HIGH_SIDE_DRIVE_STRENGTH_ADDR = 4'h5;
   localparam logic [3:0] LOW_SIDE_DRIVE_STRENGTH_ADDR = 4'h6;

   // field positions
   localparam int unsigned FAULT_FLAGS_LSB = 5;
   localparam int unsigned FAULT_FLAGS_NUM = 6;
   localparam int unsigned TIME_MSB = 9;
   localparam int unsigned TIME_LSB = 8;
   localparam int unsigned SINK_MSB = 7;
   localparam int unsigned SINK_LSB = 4;
   localparam int unsigned SRC_MSB = 3;
   localparam int unsigned SRC_LSB = 0;

   // values after reset
   localparam logic [5:0] GATE_FAULT_FLAGS_RESET = 6'h00;
   localparam logic [10:0] HIGH_SIDE_DRIVE_STRENGTH_RESET = 11'h344;
   localparam logic [10:0] LOW_SIDE_DRIVE_STRENGTH_RESET = 11'h344;

   typedef logic [10:0] gdr_value_type;

   // decoded values of the default field codes, driven while in reset
   localparam gdr_value_type SOURCE_TIME_RESET_NS = 11'h6F4;
   localparam gdr_value_type SINK_CURRENT_RESET_MA = 11'h03C;
   localparam gdr_value_type SOURCE_CURRENT_RESET_MA = 11'h032;

   // source time steps in ns
   localparam gdr_value_type TIME_220_NS = 11'h0DC;
   localparam gdr_value_type TIME_440_NS = 11'h1B8;
   localparam gdr_value_type TIME_880_NS = 11'h370;
   localparam gdr_value_type TIME_1780_NS = 11'h6F4;

   // current table points in mA
   localparam gdr_value_type STEP_MA = 11'h00A;
   localparam gdr_value_type AMP_STEP_MA = 11'h0FA;
   localparam gdr_value_type SINK_BASE_MA = 11'h014;
   localparam gdr_value_type SINK_FILL_MA = 11'h03C;
   localparam gdr_value_type SRC_BASE_MA = 11'h00A;
   localparam gdr_value_type SRC_EIGHTH_AMP_MA = 11'h07D;
   localparam gdr_value_type SRC_FILL_MA = 11'h032;
   localparam logic [3:0] LAST_FINE_CODE = 4'h6;
   localparam logic [3:0] EIGHTH_AMP_CODE = 4'h7;
   localparam logic [3:0] LAST_COARSE_CODE = 4'hB;

   // peak source time in ns
   function automatic gdr_value_type source_time_ns(input logic [1:0] code);
      unique case (code)
         2'h0: source_time_ns = TIME_220_NS;
         2'h1: source_time_ns = TIME_440_NS;
         2'h2: source_time_ns = TIME_880_NS;
         2'h3: source_time_ns = TIME_1780_NS;
      endcase
   endfunction

   // peak sink current in mA
   function automatic gdr_value_type sink_current_ma(input logic [3:0] code);
      gdr_value_type c;
      c = {7'h00, code};
      if (code <= LAST_FINE_CODE) begin
         sink_current_ma = SINK_BASE_MA + c * STEP_MA;
      end else if (code <= LAST_COARSE_CODE) begin
         sink_current_ma = (c - {7'h00, LAST_FINE_CODE}) * AMP_STEP_MA;
      end else begin
         sink_current_ma = SINK_FILL_MA;
      end
   endfunction

   // peak source current in mA
   function automatic gdr_value_type source_current_ma(input logic [3:0] code);
      gdr_value_type c;
      c = {7'h00, code};
      if (code <= LAST_FINE_CODE) begin
         source_current_ma = SRC_BASE_MA + c * STEP_MA;
      end else if (code == EIGHTH_AMP_CODE) begin
         source_current_ma = SRC_EIGHTH_AMP_MA;
      end else if (code <= LAST_COARSE_CODE) begin
         source_current_ma = (c - {7'h00, EIGHTH_AMP_CODE}) * AMP_STEP_MA;
      end else begin
         source_current_ma = SRC_FILL_MA;
      end
   endfunction

endpackage

// ===== src/gdr_pin_sync.sv
// three-stage pin synchroniser that passes a bit once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module gdr_pin_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);

   logic [WIDTH-1:0] stage1_r;
   logic [WIDTH-1:0] stage2_r;
   logic [WIDTH-1:0] stage3_r;

   // synchroniser chain, stage one feeds only stage two
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         stage1_r <= RESET_VALUE;
         stage2_r <= RESET_VALUE;
         stage3_r <= RESET_VALUE;
      end else begin
         stage1_r <= pin_in;
         stage2_r <= stage1_r;
         stage3_r <= stage2_r;
      end
   end

   // accept a bit only when the two later stages agree
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         level_out <= RESET_VALUE;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2_r[i] == stage3_r[i]) begin
               level_out[i] <= stage3_r[i];
            end
         end
      end
   end

endmodule // gdr_pin_sync

`default_nettype wire

// ===== src/gdr_bank.sv
// serial-reached gate fault flags and high/low side drive strength registers
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Read-only fault flags sit in bits 10 to 5 as high/low A, high/low B, high/low C, reset 0, bits 4:0 zero.
// - Both drive strength registers can be written and read back, returning the last written value or the default.
// - Reading and clearing faults leave the drive strength registers untouched.
// - Power-up reset loads every drive strength field with its default.
// - Entering sleep puts every drive strength field back to its default and drops what the host wrote.
// - High side bits 9:8 pick a source time of 220, 440, 880 or 1780 ns, default 11, with bit 10 stored and read back as written.
// - High side bits 7:4 pick sink current 20 to 80 mA, then 0.25 to 1.25 A, 60 mA for 12 to 15, default 0100.
// - High side bits 3:0 pick source current 10 to 70 mA, 0.125 A, 0.25 to 1.00 A, 50 mA above 11, default 0100.
// - Low side bits 9:8 pick the same four source times, default 11, with bit 10 stored and read back as written.
// - Low side bits 7:4 pick sink current with the high side sink table, default 0100.
// - Low side bits 3:0 pick source current with the high side source table, default 0100.
// - Words are 16 bits: read/write bit, four address bits, eleven data bits; answers carry data in low bits.
module gdr_bank
   import gdr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   input wire logic [5:0] gate_fault_detect,
   input wire logic clear_faults_command,
   input wire logic sleep_enter,
   output logic gate_fault_high_a,
   output logic gate_fault_low_a,
   output logic gate_fault_high_b,
   output logic gate_fault_low_b,
   output logic gate_fault_high_c,
   output logic gate_fault_low_c,
   output logic [1:0] high_side_source_time,
   output logic [3:0] high_side_sink_current,
   output logic [3:0] high_side_source_current,
   output logic [1:0] low_side_source_time,
   output logic [3:0] low_side_sink_current,
   output logic [3:0] low_side_source_current,
   output logic [10:0] high_side_source_time_ns,
   output logic [10:0] high_side_sink_current_ma,
   output logic [10:0] high_side_source_current_ma,
   output logic [10:0] low_side_source_time_ns,
   output logic [10:0] low_side_sink_current_ma,
   output logic [10:0] low_side_source_current_ma
);

   logic [8:0] pins_s;
   logic sclk_s;
   logic cs_n_s;
   logic mosi_s;
   logic [5:0] fault_s;
   logic sclk_d_r;
   logic cs_n_d_r;
   logic [4:0] bit_cnt_r;
   logic [15:0] shift_in_r;
   logic [15:0] out_word_r;
   logic [5:0] fault_flags_r;
   logic [10:0] high_side_drive_strength_r;
   logic [10:0] low_side_drive_strength_r;
   logic frame_start;
   logic frame_end;
   logic sclk_fall;
   logic sclk_rise;
   logic [3:0] read_addr;
   logic [10:0] read_data;
   logic write_ok;
   logic wr_high;
   logic wr_low;
   logic [3:0] out_index;

   // pins and fault detectors come from outside this clock domain
   gdr_pin_sync #(
      .WIDTH(9),
      .RESET_VALUE(9'h002)
   ) u_pin_sync (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .pin_in({gate_fault_detect, spi_mosi, spi_cs_n, spi_sclk}),
      .level_out(pins_s)
   );

   // split the synchronised vector
   assign sclk_s = pins_s[0];
   assign cs_n_s = pins_s[1];
   assign mosi_s = pins_s[2];
   assign fault_s = pins_s[8:3];

   // edge detection of select and serial clock
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sclk_d_r <= 1'b0;
         cs_n_d_r <= 1'b1;
      end else begin
         sclk_d_r <= sclk_s;
         cs_n_d_r <= cs_n_s;
      end
   end

   // frame events; data is taken on falling and driven on rising clock edges
   assign frame_start = cs_n_d_r & ~cs_n_s;
   assign frame_end = ~cs_n_d_r & cs_n_s;
   assign sclk_fall = ~cs_n_s & sclk_d_r & ~sclk_s;
   assign sclk_rise = ~cs_n_s & ~sclk_d_r & sclk_s;

   // address is complete with the bit taken on the fifth falling edge
   assign read_addr = {shift_in_r[2:0], mosi_s};

   // read multiplexer, unmapped addresses answer zero
   always_comb begin
      read_data = '0;
      unique case (read_addr)
         GATE_FAULT_FLAGS_ADDR: read_data[10:FAULT_FLAGS_LSB] = fault_flags_r;
         HIGH_SIDE_DRIVE_STRENGTH_ADDR: read_data = high_side_drive_strength_r;
         LOW_SIDE_DRIVE_STRENGTH_ADDR: read_data = low_side_drive_strength_r;
         default: read_data = '0;
      endcase
   end

   // a write lands only on a full 16-bit frame with the write bit
   assign write_ok = frame_end & (bit_cnt_r == FRAME_DONE_CNT) & (shift_in_r[RW_POS] != RW_READ);
   assign wr_high = write_ok & (shift_in_r[ADDR_MSB:ADDR_LSB] == HIGH_SIDE_DRIVE_STRENGTH_ADDR);
   assign wr_low = write_ok & (shift_in_r[ADDR_MSB:ADDR_LSB] == LOW_SIDE_DRIVE_STRENGTH_ADDR);

   // bit counter and input shifter
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         bit_cnt_r <= '0;
         shift_in_r <= '0;
      end else if (frame_start) begin
         bit_cnt_r <= '0;
         shift_in_r <= '0;
      end else if (sclk_fall) begin
         shift_in_r <= {shift_in_r[14:0], mosi_s};
         if (bit_cnt_r != 5'h1F) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
         end
      end
   end

   // answer word: upper five bits zero, data loaded once the address is known
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         out_word_r <= '0;
      end else if (frame_start) begin
         out_word_r <= '0;
      end else if (sclk_fall && bit_cnt_r == ADDR_DONE_CNT) begin
         out_word_r <= {5'h00, read_data};
      end
   end

   // next answer bit index follows the number of bits taken
   assign out_index = 4'hF - bit_cnt_r[3:0];

   // serial output and its enable
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         spi_miso <= 1'b0;
         spi_miso_oe <= 1'b0;
      end else begin
         spi_miso_oe <= ~cs_n_s;
         if (frame_start) begin
            spi_miso <= 1'b0;
         end else if (sclk_rise) begin
            spi_miso <= bit_cnt_r[4] ? 1'b0 : out_word_r[out_index];
         end
      end
   end

   // sticky fault flags, a detector event wins over a clear
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fault_flags_r <= GATE_FAULT_FLAGS_RESET;
      end else begin
         fault_flags_r <= (fault_flags_r & ~{FAULT_FLAGS_NUM{clear_faults_command}}) | fault_s;
      end
   end

   // fault flag outputs in register bit order
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         gate_fault_high_a <= 1'b0;
         gate_fault_low_a <= 1'b0;
         gate_fault_high_b <= 1'b0;
         gate_fault_low_b <= 1'b0;
         gate_fault_high_c <= 1'b0;
         gate_fault_low_c <= 1'b0;
      end else begin
         gate_fault_high_a <= fault_flags_r[5];
         gate_fault_low_a <= fault_flags_r[4];
         gate_fault_high_b <= fault_flags_r[3];
         gate_fault_low_b <= fault_flags_r[2];
         gate_fault_high_c <= fault_flags_r[1];
         gate_fault_low_c <= fault_flags_r[0];
      end
   end

   // high side strength; only a write or sleep entry changes it
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         high_side_drive_strength_r <= HIGH_SIDE_DRIVE_STRENGTH_RESET;
      end else if (sleep_enter) begin
         high_side_drive_strength_r <= HIGH_SIDE_DRIVE_STRENGTH_RESET;
      end else if (wr_high) begin
         high_side_drive_strength_r <= shift_in_r[10:0];
      end
   end

   // low side strength; only a write or sleep entry changes it
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         low_side_drive_strength_r <= LOW_SIDE_DRIVE_STRENGTH_RESET;
      end else if (sleep_enter) begin
         low_side_drive_strength_r <= LOW_SIDE_DRIVE_STRENGTH_RESET;
      end else if (wr_low) begin
         low_side_drive_strength_r <= shift_in_r[10:0];
      end
   end

   // raw field codes to the drivers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         high_side_source_time <= HIGH_SIDE_DRIVE_STRENGTH_RESET[TIME_MSB:TIME_LSB];
         high_side_sink_current <= HIGH_SIDE_DRIVE_STRENGTH_RESET[SINK_MSB:SINK_LSB];
         high_side_source_current <= HIGH_SIDE_DRIVE_STRENGTH_RESET[SRC_MSB:SRC_LSB];
         low_side_source_time <= LOW_SIDE_DRIVE_STRENGTH_RESET[TIME_MSB:TIME_LSB];
         low_side_sink_current <= LOW_SIDE_DRIVE_STRENGTH_RESET[SINK_MSB:SINK_LSB];
         low_side_source_current <= LOW_SIDE_DRIVE_STRENGTH_RESET[SRC_MSB:SRC_LSB];
      end else begin
         high_side_source_time <= high_side_drive_strength_r[TIME_MSB:TIME_LSB];
         high_side_sink_current <= high_side_drive_strength_r[SINK_MSB:SINK_LSB];
         high_side_source_current <= high_side_drive_strength_r[SRC_MSB:SRC_LSB];
         low_side_source_time <= low_side_drive_strength_r[TIME_MSB:TIME_LSB];
         low_side_sink_current <= low_side_drive_strength_r[SINK_MSB:SINK_LSB];
         low_side_source_current <= low_side_drive_strength_r[SRC_MSB:SRC_LSB];
      end
   end

   // decoded ns and mA settings to the drivers
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         high_side_source_time_ns <= SOURCE_TIME_RESET_NS;
         high_side_sink_current_ma <= SINK_CURRENT_RESET_MA;
         high_side_source_current_ma <= SOURCE_CURRENT_RESET_MA;
         low_side_source_time_ns <= SOURCE_TIME_RESET_NS;
         low_side_sink_current_ma <= SINK_CURRENT_RESET_MA;
         low_side_source_current_ma <= SOURCE_CURRENT_RESET_MA;
      end else begin
         high_side_source_time_ns <= source_time_ns(high_side_drive_strength_r[TIME_MSB:TIME_LSB]);
         high_side_sink_current_ma <= sink_current_ma(high_side_drive_strength_r[SINK_MSB:SINK_LSB]);
         high_side_source_current_ma <= source_current_ma(high_side_drive_strength_r[SRC_MSB:SRC_LSB]);
         low_side_source_time_ns <= source_time_ns(low_side_drive_strength_r[TIME_MSB:TIME_LSB]);
         low_side_sink_current_ma <= sink_current_ma(low_side_drive_strength_r[SINK_MSB:SINK_LSB]);
         low_side_source_current_ma <= source_current_ma(low_side_drive_strength_r[SRC_MSB:SRC_LSB]);
      end
   end

endmodule // gdr_bank

`default_nettype wire

// ===== bench/gdr_host_model.sv
// host-side serial master model for the register bank
`timescale 1ns/1ps
`default_nettype none

module gdr_host_model (
   input wire logic sys_clk,
   input wire logic spi_miso_line,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi
);
   // half period of the serial clock in system clocks, raised by the bench for a slow host
   int half = 10;

   // idle: frame select high, serial clock low
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end

   // one frame, msb first: data changes on the rising clock, both sides sample on the falling one
   task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      spi_cs_n = 1'b0;
      repeat (half) @(negedge sys_clk);
      for (int i = 15; i > 15 - nbits; i--) begin
         spi_sclk = 1'b1;
         spi_mosi = tx[i];
         repeat (half) @(negedge sys_clk);
         spi_sclk = 1'b0;
         rx[i] = spi_miso_line;
         repeat (half) @(negedge sys_clk);
      end
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi; // a released line does not keep its last value
      repeat (12) @(negedge sys_clk);
   endtask
endmodule // gdr_host_model

`default_nettype wire

// ===== bench/gdr_bank_checker.sv
// assertions on the ports of the gate drive strength and fault register bank
`timescale 1ns/1ps
`default_nettype none

module gdr_bank_checker
   import gdr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic spi_cs_n,
   input wire logic spi_miso_oe,
   input wire logic [5:0] gate_fault_detect,
   input wire logic clear_faults_command,
   input wire logic sleep_enter,
   input wire logic gate_fault_high_a,
   input wire logic gate_fault_low_c,
   input wire logic [1:0] high_side_source_time,
   input wire logic [3:0] high_side_sink_current,
   input wire logic [3:0] high_side_source_current,
   input wire logic [1:0] low_side_source_time,
   input wire logic [3:0] low_side_sink_current,
   input wire logic [3:0] low_side_source_current
);
   // field codes of each control register gathered for comparison
   wire logic [9:0] hs_code = {high_side_source_time, high_side_sink_current, high_side_source_current};
   wire logic [9:0] ls_code = {low_side_source_time, low_side_sink_current, low_side_source_current};

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // defaults, sleep and steadiness of the drive fields
   a_reset_defaults: assert property ($rose(resetn) |-> hs_code == 10'h344 && ls_code == 10'h344)
      else $error("drive fields not at default after reset");
   a_sleep_defaults: assert property (sleep_enter |-> ##2 hs_code == 10'h344 && ls_code == 10'h344)
      else $error("drive fields not at default after sleep");
   a_fields_steady: assert property ((!spi_cs_n && !sleep_enter) [*8] |->
      $stable(hs_code) && $stable(ls_code)) else $error("drive fields changed during a frame");

   // sticky fault flags
   a_flag_holds: assert property (gate_fault_high_a && !clear_faults_command
      && !$past(clear_faults_command) |=> gate_fault_high_a) else $error("fault flag dropped without a clear");
   a_flag_clears: assert property ((clear_faults_command && gate_fault_detect == 6'h00) [*8] |->
      !gate_fault_high_a && !gate_fault_low_c) else $error("fault flag survived a clear");
   a_high_a_sets: assert property (gate_fault_detect[5] [*8] |-> gate_fault_high_a)
      else $error("high side A flag not set by its detector");
   a_low_c_sets: assert property (gate_fault_detect[0] [*8] |-> gate_fault_low_c)
      else $error("low side C flag not set by its detector");

   // the response line is driven only while the frame is selected
   a_oe_follows: assert property ($stable(spi_cs_n) [*8] |-> spi_miso_oe == !spi_cs_n)
      else $error("data output enable does not follow frame select");

   c_sleep: cover property (sleep_enter);
   c_write: cover property (!$stable(hs_code));
   c_fault: cover property ($rose(gate_fault_low_c));
endmodule // gdr_bank_checker

bind gdr_bank gdr_bank_checker u_checker (.sys_clk, .resetn, .spi_cs_n, .spi_miso_oe, .gate_fault_detect,
   .clear_faults_command, .sleep_enter, .gate_fault_high_a, .gate_fault_low_c, .high_side_source_time,
   .high_side_sink_current, .high_side_source_current, .low_side_source_time, .low_side_sink_current,
   .low_side_source_current);

`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the gate drive strength and fault register bank
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
   $display("unexpected at %0t: got %h want %h", $time, (got), (exp)); end end

module testbench;
   import gdr_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [5:0] gate_fault_detect = 6'h00;
   logic clear_faults_command = 1'b0;
   logic sleep_enter = 1'b0;
   wire logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
   wire logic gate_fault_high_a, gate_fault_low_a, gate_fault_high_b;
   wire logic gate_fault_low_b, gate_fault_high_c, gate_fault_low_c;
   wire logic [1:0] high_side_source_time, low_side_source_time;
   wire logic [3:0] high_side_sink_current, high_side_source_current, low_side_sink_current, low_side_source_current;
   wire logic [10:0] high_side_source_time_ns, high_side_sink_current_ma, high_side_source_current_ma;
   wire logic [10:0] low_side_source_time_ns, low_side_sink_current_ma, low_side_source_current_ma;
   // the response line floats while the device does not drive it
   wire logic spi_miso_line = spi_miso_oe ? spi_miso : 1'bz;
   wire logic [5:0] flags = {gate_fault_high_a, gate_fault_low_a, gate_fault_high_b, gate_fault_low_b,
      gate_fault_high_c, gate_fault_low_c};
   wire logic [32:0] hd = {high_side_source_time_ns, high_side_sink_current_ma, high_side_source_current_ma};
   wire logic [32:0] ld = {low_side_source_time_ns, low_side_sink_current_ma, low_side_source_current_ma};
   int num_errors = 0;
   int total_checks = 0;
   logic [15:0] rx;
   // expected ns and mA for every field code
   logic [10:0] time_tab [4] = '{11'h0DC, 11'h1B8, 11'h370, 11'h6F4};
   logic [10:0] sink_tab [16] = '{11'h014, 11'h01E, 11'h028, 11'h032, 11'h03C, 11'h046, 11'h050, 11'h0FA,
      11'h1F4, 11'h2EE, 11'h3E8, 11'h4E2, 11'h03C, 11'h03C, 11'h03C, 11'h03C};
   logic [10:0] src_tab [16] = '{11'h00A, 11'h014, 11'h01E, 11'h028, 11'h032, 11'h03C, 11'h046, 11'h07D,
      11'h0FA, 11'h1F4, 11'h2EE, 11'h3E8, 11'h032, 11'h032, 11'h032, 11'h032};

   gdr_bank DUT (.sys_clk, .resetn, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe, .gate_fault_detect,
      .clear_faults_command, .sleep_enter, .gate_fault_high_a, .gate_fault_low_a, .gate_fault_high_b,
      .gate_fault_low_b, .gate_fault_high_c, .gate_fault_low_c, .high_side_source_time, .high_side_sink_current,
      .high_side_source_current, .low_side_source_time, .low_side_sink_current, .low_side_source_current,
      .high_side_source_time_ns, .high_side_sink_current_ma, .high_side_source_current_ma,
      .low_side_source_time_ns, .low_side_sink_current_ma, .low_side_source_current_ma);
   gdr_host_model host (.sys_clk, .spi_miso_line, .spi_sclk, .spi_cs_n, .spi_mosi);

   // 40 MHz system clock
   always #12.5 sys_clk = ~sys_clk;

   // verdict and end of run
   task automatic stop_test;
      if (num_errors == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // register write and read-back frames
   task automatic wr(input logic [3:0] a, input logic [10:0] d);
      host.frame({1'b0, a, d}, 16, rx);
   endtask
   task automatic rd(input logic [3:0] a, input logic [10:0] d);
      host.frame({1'b1, a, 11'h000}, 16, rx);
      `CHECK(rx, {5'h00, d})
   endtask

   // field codes and their decoded values on both sides
   task automatic ctrl(input logic [9:0] hs, input logic [9:0] ls);
      `CHECK({high_side_source_time, high_side_sink_current, high_side_source_current}, hs)
      `CHECK({low_side_source_time, low_side_sink_current, low_side_source_current}, ls)
      `CHECK(hd, {time_tab[hs[9:8]], sink_tab[hs[7:4]], src_tab[hs[3:0]]})
      `CHECK(ld, {time_tab[ls[9:8]], sink_tab[ls[7:4]], src_tab[ls[3:0]]})
   endtask

   // main sequence
   initial begin
      logic [10:0] h, l;
      logic [3:0] c;
      repeat (20) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (8) @(negedge sys_clk);
      ctrl(10'h344, 10'h344);
      rd(GATE_FAULT_FLAGS_ADDR, 11'h000);
      rd(HIGH_SIDE_DRIVE_STRENGTH_ADDR, 11'h344);
      rd(LOW_SIDE_DRIVE_STRENGTH_ADDR, 11'h344);
      // every code of every field, low side reserved bit included
      for (int i = 0; i < 16; i++) begin
         c = 4'(i);
         h = {1'b0, c[1:0], c, ~c};
         l = {c[0], ~c[1:0], ~c, c};
         wr(HIGH_SIDE_DRIVE_STRENGTH_ADDR, h);
         wr(LOW_SIDE_DRIVE_STRENGTH_ADDR, l);
         ctrl(h[9:0], l[9:0]);
         rd(HIGH_SIDE_DRIVE_STRENGTH_ADDR, h);
         rd(LOW_SIDE_DRIVE_STRENGTH_ADDR, l);
      end
      // each detector sets only its own flag, which stays until cleared
      for (int k = 0; k < 6; k++) begin
         gate_fault_detect = 6'h01 << k;
         repeat (10) @(negedge sys_clk);
         gate_fault_detect = 6'h00;
         repeat (10) @(negedge sys_clk);
         `CHECK(flags, 6'h01 << k)
         rd(GATE_FAULT_FLAGS_ADDR, {6'h01 << k, 5'h00});
         clear_faults_command = 1'b1;
         repeat (10) @(negedge sys_clk);
         clear_faults_command = 1'b0;
         `CHECK(flags, 6'h00)
      end
      ctrl(10'h3F0, 10'h00F);
      clear_faults_command = 1'b1;
      rd(HIGH_SIDE_DRIVE_STRENGTH_ADDR, 11'h3F0);
      clear_faults_command = 1'b0;
      // writes that must be ignored: read-only, unmapped, short frame
      wr(GATE_FAULT_FLAGS_ADDR, 11'h7FF);
      rd(GATE_FAULT_FLAGS_ADDR, 11'h000);
      wr(4'h9, 11'h155);
      rd(4'h9, 11'h000);
      host.frame({1'b0, HIGH_SIDE_DRIVE_STRENGTH_ADDR, 11'h123}, 15, rx);
      rd(HIGH_SIDE_DRIVE_STRENGTH_ADDR, 11'h3F0);
      // sleep drops host settings; a slow host reads the result
      sleep_enter = 1'b1;
      @(negedge sys_clk);
      sleep_enter = 1'b0;
      repeat (3) @(negedge sys_clk);
      ctrl(10'h344, 10'h344);
      host.half = 20;
      rd(LOW_SIDE_DRIVE_STRENGTH_ADDR, 11'h344);
      host.half = 10;
      // reset in mid-run restores defaults
      wr(HIGH_SIDE_DRIVE_STRENGTH_ADDR, 11'h0A5);
      ctrl(10'h0A5, 10'h344);
      resetn = 1'b0;
      repeat (2) @(negedge sys_clk);
      resetn = 1'b1;
      repeat (8) @(negedge sys_clk);
      ctrl(10'h344, 10'h344);
      rd(HIGH_SIDE_DRIVE_STRENGTH_ADDR, 11'h344);
      stop_test();
   end

   // cut a hang short well past the expected run of about 30k cycles
   initial begin
      repeat (60000) @(posedge sys_clk);
      num_errors++;
      stop_test();
   end
endmodule // testbench

`default_nettype wire
